// File: tcl_defines.vh
// Constants for the touch calibration loader: frame codes, memory layout,
// register offsets and field positions.
// Included by the checksum and loader design files and the bench (not the byte store); holds definitions only.
`ifndef TCL_DEFINES_VH
`define TCL_DEFINES_VH

// ****************************************************************
// Frame codes
// ****************************************************************
`define TCL_HDR          8'h55
`define TCL_CMD_EN       8'h12
`define TCL_CMD_DIS      8'h13
`define TCL_CMD_REGWR    8'h21
`define TCL_CMD_BASE     8'h22
`define TCL_CMD_PERSIST  8'h23
`define TCL_CMD_NVWR     8'h29
`define TCL_ST_OK        8'h00
`define TCL_ST_BADFMT    8'h04
`define TCL_ST_UNKNOWN   8'h03
`define TCL_ADDR_HI      8'h00
`define TCL_LEN_MIN      8'h01
`define TCL_LEN_MAX      8'h08
`define TCL_WR_OVH       8'h04
`define TCL_RESP_SHORT   3'h4
`define TCL_RESP_LONG    3'h5
`define TCL_RESP_OVH     3'h2
`define TCL_BODY_MAX     4'hB

// ****************************************************************
// Calibration image layout and checksum
// ****************************************************************
`define TCL_SEED         8'h45
`define TCL_KEY          8'h55
`define TCL_P_KEY        7'h16
`define TCL_P_FIRST      7'h17
`define TCL_P_LAST       7'h27
`define TCL_P_SUM        7'h28
`define TCL_M_KEY        7'h3E
`define TCL_M_LAST       7'h4F
`define TCL_M_SUM        7'h50

// ****************************************************************
// Registers
// ****************************************************************
`define TCL_REG_BASE     8'h20
`define TCL_REG_COUNT    5'h10
`define TCL_OFS_OPT      4'hD
`define TCL_OPT_CAL_EN   0
`define TCL_OPT_WIRE     1
`define TCL_OPT_MASK     8'h03

`endif

// File: tcl_nvm.v
// Non-volatile byte store of the loader: one write port, one read port.
// Assumes a single clock; contents are kept across reset like real storage.
`timescale 1ns/1ps
`default_nettype none
module tcl_nvm #(
  parameter DEPTH = 256,
  parameter AW    = 8
) (
  input  wire          ref_clk,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [7:0]    wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [7:0]    rd_data_ff
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  // No reset on the array: a power cycle must not erase the stored image
  reg [7:0] mem [0:DEPTH-1];

  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// File: tcl_csum.v
// Additive 8-bit checksum accumulator, seeded at reset.
// Assumes the caller presents one byte per add_en pulse.
`include "tcl_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module tcl_csum (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       add_en,
  input  wire [7:0] data,
  output reg  [7:0] sum_ff
);
  // ****************************************************************
  // Accumulator
  // ****************************************************************
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_ff <= `TCL_SEED;
    end else if (add_en) begin
      sum_ff <= sum_ff + data;
    end
  end
endmodule
`default_nettype wire

// File: tcl_loader.v
// Command interpreter of the touch calibration loader.
// Assumes bytes arrive on rx with a valid/ready handshake, synchronous to ref_clk.
//
// Contract
// - checksum is 8-bit sum, carry dropped
// - seed 0x45, add 18 bytes key..flip
// - option bit0 selects calibrated coordinates
// - option bit1 selects eight or four wire
// - option bits 7-2 read zero
// - command 0x22 returns register base address
// - command 0x21 writes addressed registers
// - command 0x23 copies registers to storage
// - loaded calibration takes effect after power-up
// - write frame: header,count,cmd,0x00,addr,length
// - length 1..8, data to consecutive locations
// - write success reply 55 02 00 29
// - reporting off 55 01 13, echoed reply; the loader replies 55 02 00 13
`include "tcl_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module tcl_loader #(
  parameter [7:0] REG_BASE = `TCL_REG_BASE
) (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire [7:0] rx_data,
  input  wire       rx_valid,
  output wire       rx_ready,
  output reg  [7:0] tx_data_ff,
  output reg        tx_valid_ff,
  input  wire       tx_ready,
  output reg        report_enable_ff,
  output reg        cal_valid_ff,
  output wire       calibrated_coord_enable,
  output wire       sensor_wire_select,
  output wire       boot_busy
);
  // ****************************************************************
  // States
  // ****************************************************************
  localparam [5:0] S_BOOT = 6'h01;
  localparam [5:0] S_HDR  = 6'h02;
  localparam [5:0] S_CNT  = 6'h04;
  localparam [5:0] S_BODY = 6'h08;
  localparam [5:0] S_EXEC = 6'h10;
  localparam [5:0] S_RESP = 6'h20;

  reg  [5:0] state_ff;
  reg  [7:0] cnt_ff;
  reg  [7:0] idx_ff;
  reg  [7:0] cmd_ff;
  reg  [7:0] body_ff [0:10];
  reg  [3:0] ptr_ff;
  reg  [7:0] regs_ff [0:15];
  reg  [7:0] status_ff;
  reg  [2:0] rlen_ff;
  reg  [2:0] ridx_ff;
  reg  [6:0] scan_ff;
  reg  [6:0] sd_ff;
  reg        sdv_ff;
  reg        pkey_ff;
  reg        mkey_ff;
  reg        pok_ff;
  integer    i;

  wire [7:0] nvm_rd;
  wire [7:0] psum;
  wire [7:0] msum;

  // ****************************************************************
  // Frame decode
  // ****************************************************************
  wire [7:0] len      = body_ff[2];
  wire [7:0] waddr    = body_ff[1];
  wire [7:0] roff     = waddr - REG_BASE;
  wire       fmt_ok   = (body_ff[0] == `TCL_ADDR_HI) && (len >= `TCL_LEN_MIN) &&
                        (len <= `TCL_LEN_MAX) && (cnt_ff == len + `TCL_WR_OVH);
  wire       reg_ok   = fmt_ok && (waddr >= REG_BASE) &&
                        ({1'b0, roff} + {1'b0, len} <= {4'h0, `TCL_REG_COUNT});
  wire       last_ptr = ({4'h0, ptr_ff} + 8'h01 == len);
  wire [3:0] roff_p   = roff[3:0] + ptr_ff;
  wire [7:0] wdata    = body_ff[ptr_ff + 4'h3];

  wire in_exec   = (state_ff == S_EXEC);
  wire is_nvwr   = in_exec && (cmd_ff == `TCL_CMD_NVWR);
  wire is_persist = in_exec && (cmd_ff == `TCL_CMD_PERSIST);

  // ****************************************************************
  // Storage and checksums
  // ****************************************************************
  wire       nvm_we = (is_nvwr && fmt_ok) || is_persist;
  wire [7:0] nvm_wa = is_persist ? {4'h0, ptr_ff} : waddr + {4'h0, ptr_ff};
  wire [7:0] nvm_wd = is_persist ? regs_ff[ptr_ff] : wdata;

  tcl_nvm #(
    .DEPTH (256),
    .AW    (8)
  ) u_nvm (
    .ref_clk    (ref_clk),
    .wr_en      (nvm_we),
    .wr_addr    (nvm_wa),
    .wr_data    (nvm_wd),
    .rd_addr    ({1'b0, scan_ff}),
    .rd_data_ff (nvm_rd)
  );

  // Primary image key..flip, and the same span of the mirror copy
  wire padd = sdv_ff && (sd_ff >= `TCL_P_KEY) && (sd_ff <= `TCL_P_LAST);
  wire madd = sdv_ff && (sd_ff >= `TCL_M_KEY) && (sd_ff <= `TCL_M_LAST);

  tcl_csum u_csum_p (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .add_en  (padd),
    .data    (nvm_rd),
    .sum_ff  (psum)
  );

  tcl_csum u_csum_m (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .add_en  (madd),
    .data    (nvm_rd),
    .sum_ff  (msum)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rx_ready  = (state_ff == S_HDR) || (state_ff == S_CNT) || (state_ff == S_BODY);
  assign boot_busy = (state_ff == S_BOOT);
  // Validity is only judged at boot, so new images wait for the next power-up
  assign calibrated_coord_enable = regs_ff[`TCL_OFS_OPT][`TCL_OPT_CAL_EN] & cal_valid_ff;
  assign sensor_wire_select = regs_ff[`TCL_OFS_OPT][`TCL_OPT_WIRE];

  function [7:0] resp_byte;
    input [2:0] n;
    begin
      case (n)
        3'h0:    resp_byte = `TCL_HDR;
        3'h1:    resp_byte = {5'h00, rlen_ff - `TCL_RESP_OVH};
        3'h2:    resp_byte = status_ff;
        3'h3:    resp_byte = cmd_ff;
        default: resp_byte = REG_BASE;
      endcase
    end
  endfunction

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff         <= S_BOOT;
      cnt_ff           <= 8'h00;
      idx_ff           <= 8'h00;
      cmd_ff           <= 8'h00;
      ptr_ff           <= 4'h0;
      status_ff        <= `TCL_ST_OK;
      rlen_ff          <= `TCL_RESP_SHORT;
      ridx_ff          <= 3'h0;
      scan_ff          <= 7'h00;
      sd_ff            <= 7'h00;
      sdv_ff           <= 1'b0;
      pkey_ff          <= 1'b0;
      mkey_ff          <= 1'b0;
      pok_ff           <= 1'b0;
      cal_valid_ff     <= 1'b0;
      report_enable_ff <= 1'b1;
      tx_data_ff       <= 8'h00;
      tx_valid_ff      <= 1'b0;
      for (i = 0; i < 11; i = i + 1) begin
        body_ff[i] <= 8'h00;
      end
      for (i = 0; i < 16; i = i + 1) begin
        regs_ff[i] <= 8'h00;
      end
    end else begin
      case (state_ff)
        S_BOOT: begin
          // Read latency of one cycle: sd_ff tags the byte now on nvm_rd
          sd_ff  <= scan_ff;
          sdv_ff <= 1'b1;
          if (scan_ff != `TCL_M_SUM) begin
            scan_ff <= scan_ff + 7'h01;
          end
          if (sdv_ff) begin
            if (sd_ff < {2'h0, `TCL_REG_COUNT}) begin
              regs_ff[sd_ff[3:0]] <= (sd_ff[3:0] == `TCL_OFS_OPT) ? (nvm_rd & `TCL_OPT_MASK) : nvm_rd;
            end
            if (sd_ff == `TCL_P_KEY) begin
              pkey_ff <= (nvm_rd == `TCL_KEY);
            end
            if (sd_ff == `TCL_M_KEY) begin
              mkey_ff <= (nvm_rd == `TCL_KEY);
            end
            if (sd_ff == `TCL_P_SUM) begin
              pok_ff <= pkey_ff && (nvm_rd == psum);
            end
            if (sd_ff == `TCL_M_SUM) begin
              // Mirror copy rescues an image whose primary is damaged
              cal_valid_ff <= pok_ff || (mkey_ff && (nvm_rd == msum));
              sdv_ff       <= 1'b0;
              state_ff     <= S_HDR;
            end
          end
        end
        S_HDR: begin
          if (rx_valid && (rx_data == `TCL_HDR)) begin
            state_ff <= S_CNT;
          end
        end
        S_CNT: begin
          if (rx_valid) begin
            cnt_ff   <= rx_data;
            idx_ff   <= 8'h00;
            state_ff <= (rx_data == 8'h00) ? S_HDR : S_BODY;
          end
        end
        S_BODY: begin
          if (rx_valid) begin
            if (idx_ff == 8'h00) begin
              cmd_ff <= rx_data;
            end else if (idx_ff <= {4'h0, `TCL_BODY_MAX}) begin
              body_ff[idx_ff[3:0] - 4'h1] <= rx_data;
            end
            idx_ff <= idx_ff + 8'h01;
            if (idx_ff + 8'h01 == cnt_ff) begin
              ptr_ff   <= 4'h0;
              state_ff <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          status_ff <= `TCL_ST_OK;
          rlen_ff   <= `TCL_RESP_SHORT;
          case (cmd_ff)
            `TCL_CMD_NVWR: begin
              if (!fmt_ok) begin
                status_ff <= `TCL_ST_BADFMT;
                state_ff  <= S_RESP;
              end else if (last_ptr) begin
                state_ff <= S_RESP;
              end else begin
                ptr_ff <= ptr_ff + 4'h1;
              end
            end
            `TCL_CMD_REGWR: begin
              if (!reg_ok) begin
                status_ff <= `TCL_ST_BADFMT;
                state_ff  <= S_RESP;
              end else begin
                regs_ff[roff_p] <= (roff_p == `TCL_OFS_OPT) ? (wdata & `TCL_OPT_MASK) : wdata;
                if (last_ptr) begin
                  state_ff <= S_RESP;
                end else begin
                  ptr_ff <= ptr_ff + 4'h1;
                end
              end
            end
            `TCL_CMD_PERSIST: begin
              if ({1'b0, ptr_ff} + 5'h01 == `TCL_REG_COUNT) begin
                state_ff <= S_RESP;
              end else begin
                ptr_ff <= ptr_ff + 4'h1;
              end
            end
            `TCL_CMD_BASE: begin
              rlen_ff  <= `TCL_RESP_LONG;
              state_ff <= S_RESP;
            end
            `TCL_CMD_EN: begin
              report_enable_ff <= 1'b1;
              state_ff         <= S_RESP;
            end
            `TCL_CMD_DIS: begin
              report_enable_ff <= 1'b0;
              state_ff         <= S_RESP;
            end
            default: begin
              status_ff <= `TCL_ST_UNKNOWN;
              state_ff  <= S_RESP;
            end
          endcase
          if (state_ff != S_RESP) begin
            tx_data_ff  <= `TCL_HDR;
            ridx_ff     <= 3'h0;
          end
        end
        S_RESP: begin
          // Header byte was loaded on entry; raise valid, then step on ready
          if (!tx_valid_ff) begin
            tx_valid_ff <= 1'b1;
          end else if (tx_ready) begin
            if (ridx_ff + 3'h1 == rlen_ff) begin
              tx_valid_ff <= 1'b0;
              state_ff    <= S_HDR;
            end else begin
              ridx_ff    <= ridx_ff + 3'h1;
              tx_data_ff <= resp_byte(ridx_ff + 3'h1);
            end
          end
        end
        default: begin
          state_ff <= S_HDR;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: tcl_loader_asserts.sv
// Checker for the loader's reply, reporting and option ports.
// Bound to tcl_loader; sees only its top-level ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module tcl_loader_asserts (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       rx_ready,
  input wire logic [7:0] tx_data_ff,
  input wire logic       tx_valid_ff,
  input wire logic       tx_ready,
  input wire logic       report_enable_ff,
  input wire logic       cal_valid_ff,
  input wire logic       calibrated_coord_enable,
  input wire logic       sensor_wire_select,
  input wire logic       boot_busy
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_coord_gated: assert property (calibrated_coord_enable |-> cal_valid_ff)
    else $error("coord enable without valid image");
  a_valid_frozen: assert property (!boot_busy && !$past(boot_busy) && $past(rst_n) |-> $stable(cal_valid_ff))
    else $error("image validity moved outside boot");
  a_tx_stands: assert property (tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_data_ff))
    else $error("reply byte dropped before taken");
  a_reply_header: assert property ($rose(tx_valid_ff) |-> tx_data_ff == 8'h55)
    else $error("reply does not open with header");
  a_reply_blocks: assert property (tx_valid_ff |-> !rx_ready)
    else $error("command byte accepted during reply");
  a_report_off: assert property ($fell(report_enable_ff) |-> ##[0:4] tx_valid_ff)
    else $error("reporting off without reply");
  a_report_on: assert property ($rose(report_enable_ff) && $past(rst_n) |-> ##[0:4] tx_valid_ff)
    else $error("reporting on without reply");
  a_wire_change: assert property ($changed(sensor_wire_select) && $past(rst_n) |-> !rx_ready)
    else $error("wire select moved while idle");
  a_boot_ends: assert property ($rose(rst_n) |-> ##[1:300] !boot_busy)
    else $error("boot scan too long");
endmodule
bind tcl_loader tcl_loader_asserts i_asserts (
  .ref_clk                 (ref_clk),
  .rst_n                   (rst_n),
  .rx_ready                (rx_ready),
  .tx_data_ff              (tx_data_ff),
  .tx_valid_ff             (tx_valid_ff),
  .tx_ready                (tx_ready),
  .report_enable_ff        (report_enable_ff),
  .cal_valid_ff            (cal_valid_ff),
  .calibrated_coord_enable (calibrated_coord_enable),
  .sensor_wire_select      (sensor_wire_select),
  .boot_busy               (boot_busy)
);
`default_nettype wire

// File: tcl_host_model.sv
// Host processor model: sends one framed command, collects its reply.
// Assumes the loader's byte handshakes on ref_clk; stall slows reply intake.
`timescale 1ns/1ps
`default_nettype none
module tcl_host_model (
  input wire logic        ref_clk,
  output var logic [7:0] rx_data,
  output var logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic [7:0]  tx_data_ff,
  input wire logic        tx_valid_ff,
  output var logic        tx_ready
);
  logic [7:0] frame [$];
  logic [7:0] reply [$];
  int         stall = 0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // ****************************************************************
  // One command and its reply
  // ****************************************************************
  task automatic exchange(input int nrep, output bit ok);
    int g;
    ok = 1'b1;
    reply = {};
    foreach (frame[i]) begin
      rx_valid <= 1'b1;
      rx_data <= frame[i];
      g = 0;
      @(negedge ref_clk);
      while (rx_ready !== 1'b1 && g < 400) begin
        @(negedge ref_clk);
        g++;
      end
      if (g >= 400) ok = 1'b0;
      @(posedge ref_clk);
    end
    // Released data shows a changed value so stale bytes are never trusted
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    tx_ready <= 1'b1;
    for (int k = 0; k < nrep; k++) begin
      g = 0;
      @(negedge ref_clk);
      while (tx_valid_ff !== 1'b1 && g < 400) begin
        @(negedge ref_clk);
        g++;
      end
      if (g >= 400) ok = 1'b0;
      reply.push_back(tx_data_ff);
      @(posedge ref_clk);
      if (stall > 0 && k < nrep - 1) begin
        tx_ready <= 1'b0;
        repeat (stall) @(posedge ref_clk);
        tx_ready <= 1'b1;
      end
    end
    tx_ready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tcl_loader_tb.sv
// Self-checking bench: loads a calibration image, sets options, reboots.
// Assumes tcl_loader with its default register base and the host model.
`include "tcl_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module tcl_loader_tb;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] rx_data, tx_data_ff;
  logic       rx_valid, rx_ready, tx_valid_ff, tx_ready;
  logic       report_enable_ff, cal_valid_ff, cal_en, wire_sel, boot_busy;
  int         fail_count = 0;
  int         num_checks = 0;
  logic [7:0] img [0:18];
  always #25 ref_clk = ~ref_clk;
  tcl_host_model i_host (.ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data_ff(tx_data_ff), .tx_valid_ff(tx_valid_ff), .tx_ready(tx_ready));
  tcl_loader i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data_ff(tx_data_ff), .tx_valid_ff(tx_valid_ff), .tx_ready(tx_ready),
    .report_enable_ff(report_enable_ff), .cal_valid_ff(cal_valid_ff), .calibrated_coord_enable(cal_en),
    .sensor_wire_select(wire_sel), .boot_busy(boot_busy));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask
  task automatic do_reset();
    int g;
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    g = 0;
    do begin
      @(negedge ref_clk);
      g++;
    end while (!(boot_busy === 1'b0 && rx_ready === 1'b1) && g < 400);
    if (g >= 400) begin
      fail_count++;
      stop_test();
    end
    @(posedge ref_clk);
  endtask
  task automatic xchg(input logic [7:0] f[$], input logic [7:0] e[$]);
    bit ok;
    i_host.frame = f;
    i_host.exchange(e.size(), ok);
    if (!ok) begin
      fail_count++;
      stop_test();
    end
    foreach (e[k]) check(i_host.reply[k], e[k]);
  endtask
  task automatic nvwr(input logic [7:0] a, input int s, input int n, input logic [7:0] st);
    logic [7:0] f [$];
    f = {`TCL_HDR, 8'(n + 4), `TCL_CMD_NVWR, 8'h00, a, 8'(n)};
    for (int k = 0; k < n; k++) f.push_back(s < 0 ? 8'h00 : img[s + k]);
    xchg(f, {`TCL_HDR, 8'h02, st, `TCL_CMD_NVWR});
  endtask
  task automatic regwr(input logic [7:0] v);
    xchg({`TCL_HDR, 8'h05, `TCL_CMD_REGWR, 8'h00, `TCL_REG_BASE + `TCL_OFS_OPT, 8'h01, v},
         {`TCL_HDR, 8'h02, `TCL_ST_OK, `TCL_CMD_REGWR});
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_load();
    logic [7:0] sum;
    img = '{8'h55, 8'h06, 8'h1B, 8'hA5, 8'h08, 8'h13, 8'hDF, 8'hF4, 8'h0B, 8'h98,
            8'hE4, 8'h1E, 8'hEC, 8'hBF, 8'h1A, 8'h32, 8'hE7, 8'h01, 8'h00};
    sum = 8'h45;
    for (int k = 0; k < 18; k++) sum = sum + img[k];
    img[18] = sum;
    xchg({`TCL_HDR, 8'h01, `TCL_CMD_DIS}, {`TCL_HDR, 8'h02, `TCL_ST_OK, `TCL_CMD_DIS});
    check(8'(report_enable_ff), 8'h00);
    for (int b = 0; b < 2; b++)
      for (int c = 0; c < 3; c++)
        nvwr((b ? 8'h3E : 8'h16) + 8'(8 * c), 8 * c, c == 2 ? 3 : 8, `TCL_ST_OK);
    nvwr(8'h16, -1, 9, `TCL_ST_BADFMT);
    nvwr(8'h3E, -1, 9, `TCL_ST_BADFMT);
    nvwr(8'h16, -1, 0, `TCL_ST_BADFMT);
    $display("test load done");
  endtask
  task automatic t_options();
    i_host.stall = 3;
    xchg({`TCL_HDR, 8'h01, `TCL_CMD_BASE}, {`TCL_HDR, 8'h03, `TCL_ST_OK, `TCL_CMD_BASE, `TCL_REG_BASE});
    i_host.stall = 0;
    regwr(8'hFE);
    check(8'(wire_sel), 8'h01);
    regwr(8'h01);
    check(8'(wire_sel), 8'h00);
    // Offset past the register file must be refused and leave the option bits alone
    xchg({`TCL_HDR, 8'h05, `TCL_CMD_REGWR, 8'h00, `TCL_REG_BASE + 8'h1D, 8'h01, 8'h02},
         {`TCL_HDR, 8'h02, `TCL_ST_BADFMT, `TCL_CMD_REGWR});
    check(8'(wire_sel), 8'h00);
    check(8'(cal_valid_ff === 1'b1), 8'h00);
    xchg({`TCL_HDR, 8'h01, `TCL_CMD_PERSIST}, {`TCL_HDR, 8'h02, `TCL_ST_OK, `TCL_CMD_PERSIST});
    xchg({`TCL_HDR, 8'h01, 8'h30}, {`TCL_HDR, 8'h02, `TCL_ST_UNKNOWN, 8'h30});
    xchg({`TCL_HDR, 8'h01, `TCL_CMD_EN}, {`TCL_HDR, 8'h02, `TCL_ST_OK, `TCL_CMD_EN});
    check(8'(report_enable_ff), 8'h01);
    $display("test options done");
  endtask
  task automatic t_reboot();
    do_reset();
    check(8'(cal_valid_ff), 8'h01);
    check(8'(cal_en), 8'h01);
    check(8'(wire_sel), 8'h00);
    regwr(8'h00);
    check(8'(cal_en), 8'h00);
    regwr(8'hFF);
    check({6'h00, wire_sel, cal_en}, 8'h03);
    $display("test reboot done");
  endtask
  initial begin
    do_reset();
    t_load();
    t_options();
    t_reboot();
    stop_test();
  end
endmodule
`default_nettype wire
